// ### verilog/spsc_defines.svh
// Register offsets, field positions, reset values and timing counts of the sleep power switch control
`ifndef SPSC_DEFINES_SVH
`define SPSC_DEFINES_SVH

// Register offsets
`define SPSC_OFS_OSC_CTRL 8'h1C
`define SPSC_OFS_OUT_CTRL 8'h30
`define SPSC_OFS_SLEEP_CTRL 8'h40
`define SPSC_OFS_SWITCH_CTRL 8'h41
`define SPSC_OFS_STATUS 8'h42

// Oscillator control fields
`define SPSC_BIT_SERIAL_PINS_SLEEP_DIS 2

// Output control fields
`define SPSC_BIT_CLKOUT_SLEEP_KEEP 0
`define SPSC_BIT_INT_OUT_A 1
`define SPSC_BIT_INT_OUT_B 2
`define SPSC_BIT_RESET_SLEEP_KEEP 3
`define SPSC_BIT_INT_IN_DIS 4
`define SPSC_BIT_WAKE_IN_SLEEP_DIS 5

// Sleep control fields
`define SPSC_BIT_SLEEP_REQUEST 7
`define SPSC_BIT_SLEEP_RESET_EN 6
`define SPSC_BIT_SLEEP_FLAG 5
`define SPSC_WAIT_LSB 0
`define SPSC_WAIT_W 3

// Switch control fields
`define SPSC_SRC_LSB 0
`define SPSC_SRC_W 3
`define SPSC_BIT_STATIC_LEVEL 5
`define SPSC_BIT_SWITCH_LOCK 6
`define SPSC_BIT_OPEN_DRAIN_SEL 7
`define SPSC_SRC_SLEEP 3'h6
`define SPSC_SRC_STATIC 3'h7

// Status fields
`define SPSC_BIT_WAKE_PIN 0
`define SPSC_BIT_ARMED 1
`define SPSC_STATE_LSB 2

// Reset values
`define SPSC_RST_OSC_CTRL 8'h00
`define SPSC_RST_OUT_CTRL 8'h00
`define SPSC_RST_SLEEP_CTRL 8'h00
`define SPSC_RST_SWITCH_CTRL 8'hC7

// Timing
`define SPSC_CLK_PERIOD_NS 10
`define SPSC_WAIT_PERIOD_MS 8
`define SPSC_TICK_CYCLES ((`SPSC_WAIT_PERIOD_MS * 1000000) / `SPSC_CLK_PERIOD_NS)

`endif

// ### verilog/spsc_pkg.sv
// Types shared by the sleep power switch control
package spsc_pkg;
    typedef enum logic [1:0] {SPSC_RUN, SPSC_SWAIT, SPSC_SLEEP} spsc_state_t;
endpackage

// ### verilog/spsc_period_tick.sv
// Divider that gives a one-cycle pulse once per sleep wait period
`timescale 1ns/1ps
module spsc_period_tick #(
    parameter int unsigned CYCLES = 800000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Period pulse
    output logic tick
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb
    begin
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CW'(CYCLES - 1))
        begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule // spsc_period_tick

// ### verilog/spsc_core.sv
// Sleep request gating, sleep state machine, power switch source and sleep pin control
// Summary of operation
// - Sleep request refused unless clock halt is clear and a wake source is armed.
// - Armed when alarm interrupt enable or external interrupt enable is set.
// - Countdown timer arms only with both its interrupt and run enables set.
// - Watchdog arms only with nonzero count and steering to interrupt, not reset.
// - Sleep request refused while any interrupt is pending; bit reads zero.
// - Source select 7 (reset value) drives switch from static level, reset zero.
// - Static level cannot be raised to 1 while switch lock is set.
// - Clock/interrupt output disabled in sleep when its keep bit is clear.
// - Reset output disabled in sleep when its keep bit is clear.
// - Wake input disabled in sleep when its disable bit is set.
// - Output control bits 1 and 2 at zero disconnect internal outputs in sleep.
// - Output control bit 4 at one disables an internal input in sleep.
// - Serial pins disabled in sleep when oscillator control bit 2 is set.
// - Sleep-sourced switch held low in run; in sleep released open, or driven high in push-pull.
// - Power-up selects the static level, zero, as switch source (111b; sleep 110b).
// - Sleep reset enable drives reset low in sleep when the reset keep bit is set, released on wake.
// - Software can read the wake input pin level.
// - Entering sleep sets the occurred flag, raises switch when its source is sleep (110b); any interrupt wakes.
// - Wait field N waits N to N+1 periods of 8 ms; zero sleeps at once.
`timescale 1ns/1ps
`include "spsc_defines.svh"
module spsc_core #(
    parameter int unsigned TICK_CYCLES = `SPSC_TICK_CYCLES,
    parameter int unsigned WDOG_W = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Wake source enables and interrupt state
    input wire logic alarm_int_enable,
    input wire logic countdown_int_enable,
    input wire logic countdown_run,
    input wire logic ext_int_enable,
    input wire logic [WDOG_W-1:0] watchdog_count,
    input wire logic watchdog_steer,
    input wire logic clock_halt,
    input wire logic irq_pending,
    input wire logic wake_input_pin,
    // Power switch pin
    output logic power_switch_out,
    output logic power_switch_oe,
    // Reset pin
    output logic reset_out_n,
    output logic reset_out_oe,
    // Pin enables for sleep
    output logic clkint_out_enable,
    output logic wake_input_enable,
    output logic serial_pins_enable,
    output logic [1:0] internal_out_connect,
    output logic internal_in_disable,
    // Machine state
    output spsc_pkg::spsc_state_t sleep_state
);
    import spsc_pkg::*;

    // A sized copy of the reset value, so that fields can be selected from it
    localparam logic [7:0] SW_RST = `SPSC_RST_SWITCH_CTRL;

    logic tick;
    logic wake_source_armed;
    logic accept;
    logic sleep_wr;
    logic in_sleep;
    logic sw_level;

    logic [7:0] osc_ctrl_r, osc_ctrl_nxt;
    logic [7:0] out_ctrl_r, out_ctrl_nxt;
    logic sleep_request_r, sleep_request_nxt;
    logic sleep_reset_enable_r, sleep_reset_enable_nxt;
    logic sleep_occurred_flag_r, sleep_occurred_flag_nxt;
    logic [2:0] sleep_wait_periods_r, sleep_wait_periods_nxt;
    logic [2:0] switch_source_select_r, switch_source_select_nxt;
    logic switch_static_level_r, switch_static_level_nxt;
    logic switch_lock_r, switch_lock_nxt;
    logic switch_open_drain_sel_r, switch_open_drain_sel_nxt;
    logic [3:0] wait_cnt_r, wait_cnt_nxt;
    spsc_state_t state_r, state_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    logic psw_out_r, psw_out_nxt;
    logic psw_oe_r, psw_oe_nxt;
    logic rst_n_r, rst_n_nxt;
    logic rst_oe_r, rst_oe_nxt;
    logic clkint_en_r, clkint_en_nxt;
    logic wake_en_r, wake_en_nxt;
    logic serial_en_r, serial_en_nxt;
    logic [1:0] int_conn_r, int_conn_nxt;
    logic int_in_dis_r, int_in_dis_nxt;
    logic level_r, level_nxt;

    spsc_period_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(tick)
    );

    assign wake_source_armed = alarm_int_enable | ext_int_enable
        | (countdown_int_enable & countdown_run)
        | ((watchdog_count != '0) & ~watchdog_steer);
    assign accept = ~clock_halt & wake_source_armed & ~irq_pending;
    assign sleep_wr = reg_wr && (reg_addr == `SPSC_OFS_SLEEP_CTRL);

    // Registers and sleep state machine
    always_comb
    begin
        osc_ctrl_nxt = osc_ctrl_r;
        out_ctrl_nxt = out_ctrl_r;
        sleep_request_nxt = sleep_request_r;
        sleep_reset_enable_nxt = sleep_reset_enable_r;
        sleep_occurred_flag_nxt = sleep_occurred_flag_r;
        sleep_wait_periods_nxt = sleep_wait_periods_r;
        switch_source_select_nxt = switch_source_select_r;
        switch_static_level_nxt = switch_static_level_r;
        switch_lock_nxt = switch_lock_r;
        switch_open_drain_sel_nxt = switch_open_drain_sel_r;
        wait_cnt_nxt = wait_cnt_r;
        state_nxt = state_r;
        rdata_nxt = rdata_r;
        if (reg_wr)
        begin
            case (reg_addr)
                `SPSC_OFS_OSC_CTRL: osc_ctrl_nxt = reg_wdata;
                `SPSC_OFS_OUT_CTRL: out_ctrl_nxt = reg_wdata;
                `SPSC_OFS_SLEEP_CTRL:
                begin
                    sleep_reset_enable_nxt = reg_wdata[`SPSC_BIT_SLEEP_RESET_EN];
                    sleep_wait_periods_nxt = reg_wdata[`SPSC_WAIT_LSB +: `SPSC_WAIT_W];
                    sleep_occurred_flag_nxt = sleep_occurred_flag_r & reg_wdata[`SPSC_BIT_SLEEP_FLAG];
                end
                `SPSC_OFS_SWITCH_CTRL:
                begin
                    switch_source_select_nxt = reg_wdata[`SPSC_SRC_LSB +: `SPSC_SRC_W];
                    switch_lock_nxt = reg_wdata[`SPSC_BIT_SWITCH_LOCK];
                    switch_open_drain_sel_nxt = reg_wdata[`SPSC_BIT_OPEN_DRAIN_SEL];
                    // Raising the static level needs the lock already clear
                    if (!reg_wdata[`SPSC_BIT_STATIC_LEVEL] || !switch_lock_r)
                    begin
                        switch_static_level_nxt = reg_wdata[`SPSC_BIT_STATIC_LEVEL];
                    end
                end
                default: ;
            endcase
        end
        case (state_r)
            SPSC_RUN:
            begin
                if (sleep_wr && reg_wdata[`SPSC_BIT_SLEEP_REQUEST] && accept)
                begin
                    sleep_request_nxt = 1'b1;
                    if (reg_wdata[`SPSC_WAIT_LSB +: `SPSC_WAIT_W] == 3'h0)
                    begin
                        state_nxt = SPSC_SLEEP;
                        sleep_occurred_flag_nxt = 1'b1;
                    end
                    else
                    begin
                        state_nxt = SPSC_SWAIT;
                        // First tick lands anywhere in a period, so count one extra
                        wait_cnt_nxt = {1'b0, reg_wdata[`SPSC_WAIT_LSB +: `SPSC_WAIT_W]} + 4'h1;
                    end
                end
            end
            SPSC_SWAIT:
            begin
                if (irq_pending)
                begin
                    state_nxt = SPSC_RUN;
                    sleep_request_nxt = 1'b0;
                end
                else if (wait_cnt_r == 4'h0)
                begin
                    state_nxt = SPSC_SLEEP;
                    sleep_occurred_flag_nxt = 1'b1;
                end
                else if (tick)
                begin
                    wait_cnt_nxt = wait_cnt_r - 4'h1;
                end
            end
            SPSC_SLEEP:
            begin
                if (irq_pending)
                begin
                    state_nxt = SPSC_RUN;
                    sleep_request_nxt = 1'b0;
                end
            end
            default: state_nxt = SPSC_RUN;
        endcase
        if (reg_rd)
        begin
            case (reg_addr)
                `SPSC_OFS_OSC_CTRL: rdata_nxt = osc_ctrl_r;
                `SPSC_OFS_OUT_CTRL: rdata_nxt = out_ctrl_r;
                `SPSC_OFS_SLEEP_CTRL: rdata_nxt = {sleep_request_r, sleep_reset_enable_r,
                    sleep_occurred_flag_r, 2'h0, sleep_wait_periods_r};
                `SPSC_OFS_SWITCH_CTRL: rdata_nxt = {switch_open_drain_sel_r, switch_lock_r,
                    switch_static_level_r, 2'h0, switch_source_select_r};
                `SPSC_OFS_STATUS: rdata_nxt = {4'h0, state_r, wake_source_armed, wake_input_pin};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            osc_ctrl_r <= `SPSC_RST_OSC_CTRL;
            out_ctrl_r <= `SPSC_RST_OUT_CTRL;
            sleep_request_r <= 1'b0;
            sleep_reset_enable_r <= 1'b0;
            sleep_occurred_flag_r <= 1'b0;
            sleep_wait_periods_r <= 3'h0;
            switch_source_select_r <= SW_RST[`SPSC_SRC_LSB +: `SPSC_SRC_W];
            switch_static_level_r <= SW_RST[`SPSC_BIT_STATIC_LEVEL];
            switch_lock_r <= SW_RST[`SPSC_BIT_SWITCH_LOCK];
            switch_open_drain_sel_r <= SW_RST[`SPSC_BIT_OPEN_DRAIN_SEL];
            wait_cnt_r <= 4'h0;
            state_r <= SPSC_RUN;
            rdata_r <= 8'h00;
        end
        else
        begin
            osc_ctrl_r <= osc_ctrl_nxt;
            out_ctrl_r <= out_ctrl_nxt;
            sleep_request_r <= sleep_request_nxt;
            sleep_reset_enable_r <= sleep_reset_enable_nxt;
            sleep_occurred_flag_r <= sleep_occurred_flag_nxt;
            sleep_wait_periods_r <= sleep_wait_periods_nxt;
            switch_source_select_r <= switch_source_select_nxt;
            switch_static_level_r <= switch_static_level_nxt;
            switch_lock_r <= switch_lock_nxt;
            switch_open_drain_sel_r <= switch_open_drain_sel_nxt;
            wait_cnt_r <= wait_cnt_nxt;
            state_r <= state_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign in_sleep = (state_r == SPSC_SLEEP);
    assign sw_level = (switch_source_select_r == `SPSC_SRC_STATIC) ? switch_static_level_r
        : (switch_source_select_r == `SPSC_SRC_SLEEP) ? in_sleep : 1'b0;

    // Pin drivers
    always_comb
    begin
        level_nxt = sw_level;
        // Open drain pulls low while the level is low and floats while high
        psw_out_nxt = switch_open_drain_sel_r ? 1'b0 : sw_level;
        psw_oe_nxt = switch_open_drain_sel_r ? ~sw_level : 1'b1;
        rst_n_nxt = ~(in_sleep & sleep_reset_enable_r);
        rst_oe_nxt = ~(in_sleep & ~out_ctrl_r[`SPSC_BIT_RESET_SLEEP_KEEP]);
        clkint_en_nxt = ~(in_sleep & ~out_ctrl_r[`SPSC_BIT_CLKOUT_SLEEP_KEEP]);
        wake_en_nxt = ~(in_sleep & out_ctrl_r[`SPSC_BIT_WAKE_IN_SLEEP_DIS]);
        serial_en_nxt = ~(in_sleep & osc_ctrl_r[`SPSC_BIT_SERIAL_PINS_SLEEP_DIS]);
        int_conn_nxt[0] = ~(in_sleep & ~out_ctrl_r[`SPSC_BIT_INT_OUT_A]);
        int_conn_nxt[1] = ~(in_sleep & ~out_ctrl_r[`SPSC_BIT_INT_OUT_B]);
        int_in_dis_nxt = in_sleep & out_ctrl_r[`SPSC_BIT_INT_IN_DIS];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            level_r <= 1'b0;
            psw_out_r <= 1'b0;
            psw_oe_r <= 1'b1;
            rst_n_r <= 1'b1;
            rst_oe_r <= 1'b1;
            clkint_en_r <= 1'b1;
            wake_en_r <= 1'b1;
            serial_en_r <= 1'b1;
            int_conn_r <= 2'h3;
            int_in_dis_r <= 1'b0;
        end
        else
        begin
            level_r <= level_nxt;
            psw_out_r <= psw_out_nxt;
            psw_oe_r <= psw_oe_nxt;
            rst_n_r <= rst_n_nxt;
            rst_oe_r <= rst_oe_nxt;
            clkint_en_r <= clkint_en_nxt;
            wake_en_r <= wake_en_nxt;
            serial_en_r <= serial_en_nxt;
            int_conn_r <= int_conn_nxt;
            int_in_dis_r <= int_in_dis_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign power_switch_out = psw_out_r;
    assign power_switch_oe = psw_oe_r;
    assign reset_out_n = rst_n_r;
    assign reset_out_oe = rst_oe_r;
    assign clkint_out_enable = clkint_en_r;
    assign wake_input_enable = wake_en_r;
    assign serial_pins_enable = serial_en_r;
    assign internal_out_connect = int_conn_r;
    assign internal_in_disable = int_in_dis_r;
    assign sleep_state = state_r;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_refuse;
        (state_r == SPSC_RUN) && sleep_wr && reg_wdata[`SPSC_BIT_SLEEP_REQUEST] && !accept
            |=> !sleep_request_r && (state_r == SPSC_RUN);
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused sleep request was stored");

    property p_pending;
        (state_r == SPSC_RUN) && sleep_wr && irq_pending |=> !sleep_request_r;
    endproperty
    a_pending: assert property (p_pending) else $error("sleep request set with interrupt pending");

    property p_accept;
        (state_r == SPSC_RUN) && sleep_wr && reg_wdata[`SPSC_BIT_SLEEP_REQUEST] && accept
            |=> sleep_request_r && (state_r != SPSC_RUN);
    endproperty
    a_accept: assert property (p_accept) else $error("accepted sleep request did not start");

    property p_armed;
        reg_rd && (reg_addr == `SPSC_OFS_STATUS) && (alarm_int_enable || ext_int_enable
            || (countdown_int_enable && countdown_run) || (watchdog_count != '0 && !watchdog_steer))
            |=> reg_rdata[`SPSC_BIT_ARMED];
    endproperty
    a_armed: assert property (p_armed) else $error("armed indicator wrong");

    property p_wait0;
        (state_r == SPSC_RUN) && sleep_wr && reg_wdata[`SPSC_BIT_SLEEP_REQUEST] && accept
            && (reg_wdata[`SPSC_WAIT_LSB +: `SPSC_WAIT_W] == 3'h0) |=> in_sleep && sleep_occurred_flag_r;
    endproperty
    a_wait0: assert property (p_wait0) else $error("zero wait did not sleep at once");

    property p_static;
        (switch_source_select_r == `SPSC_SRC_STATIC) |=> level_r == $past(switch_static_level_r);
    endproperty
    a_static: assert property (p_static) else $error("switch not driven by static level");

    property p_lock;
        reg_wr && (reg_addr == `SPSC_OFS_SWITCH_CTRL) && switch_lock_r && !switch_static_level_r
            |=> !switch_static_level_r;
    endproperty
    a_lock: assert property (p_lock) else $error("static level raised while locked");

    property p_psw_sleep;
        (switch_source_select_r == `SPSC_SRC_SLEEP) && switch_open_drain_sel_r
            |=> power_switch_oe == !$past(in_sleep) && !power_switch_out;
    endproperty
    a_psw_sleep: assert property (p_psw_sleep) else $error("sleep switch not released in sleep");

    property p_pins;
        in_sleep && !out_ctrl_r[`SPSC_BIT_CLKOUT_SLEEP_KEEP] && out_ctrl_r[`SPSC_BIT_WAKE_IN_SLEEP_DIS]
            |=> !clkint_out_enable && !wake_input_enable;
    endproperty
    a_pins: assert property (p_pins) else $error("pins not disabled in sleep");

    property p_rst;
        in_sleep && sleep_reset_enable_r |=> !reset_out_n;
    endproperty
    a_rst: assert property (p_rst) else $error("reset not driven in sleep");

    property p_serial;
        in_sleep && osc_ctrl_r[`SPSC_BIT_SERIAL_PINS_SLEEP_DIS] |=> !serial_pins_enable;
    endproperty
    a_serial: assert property (p_serial) else $error("serial pins left on in sleep");

    property p_wake;
        in_sleep && irq_pending |=> (state_r == SPSC_RUN) && !sleep_request_r;
    endproperty
    a_wake: assert property (p_wake) else $error("interrupt did not wake");

    c_sleep: cover property (state_r == SPSC_SWAIT ##1 state_r == SPSC_SLEEP);
    c_wake: cover property (in_sleep ##1 state_r == SPSC_RUN);
    c_abort: cover property (state_r == SPSC_SWAIT ##1 state_r == SPSC_RUN);
    c_refuse: cover property (sleep_wr && reg_wdata[`SPSC_BIT_SLEEP_REQUEST] && !accept);
endmodule // spsc_core

// ### tb/spsc_host_model.sv
// Behavioural host whose ground is switched and whose reset comes from the block
`timescale 1ns/1ps
module spsc_host_model (
    // Pins from the block
    input wire logic power_switch_out,
    input wire logic power_switch_oe,
    input wire logic reset_out_n,
    input wire logic reset_out_oe,
    // Host condition
    output logic host_powered,
    output logic host_in_reset
);
    // Ground path exists only while the switch pulls low; released means no power
    assign host_powered = power_switch_oe & ~power_switch_out;
    // Reset line has a pull-up, so only a driven low resets the host
    assign host_in_reset = reset_out_oe & ~reset_out_n;
endmodule // spsc_host_model

// ### tb/sleep_power_switch_control_tb_top.sv
// Self-checking testbench of the sleep power switch control core
`timescale 1ns/1ps
module sleep_power_switch_control_tb_top;
    import spsc_pkg::*;
    logic clk, rst, reg_wr, reg_rd, alarm_int_enable, countdown_int_enable, countdown_run, ext_int_enable;
    logic watchdog_steer, clock_halt, irq_pending, wake_input_pin, power_switch_out, power_switch_oe;
    logic reset_out_n, reset_out_oe, clkint_out_enable, wake_input_enable, serial_pins_enable;
    logic internal_in_disable, host_powered, host_in_reset;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [4:0] watchdog_count;
    logic [1:0] internal_out_connect;
    spsc_state_t sleep_state;
    int fail_count = 0;
    int checks_done = 0;
    logic [9:0] pins;
    assign pins = {power_switch_oe, clkint_out_enable, reset_out_oe, reset_out_n, wake_input_enable,
        serial_pins_enable, internal_out_connect, internal_in_disable, host_powered};
    spsc_core #(.TICK_CYCLES(20)) i_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .alarm_int_enable(alarm_int_enable), .countdown_int_enable(countdown_int_enable),
        .countdown_run(countdown_run), .ext_int_enable(ext_int_enable), .watchdog_count(watchdog_count),
        .watchdog_steer(watchdog_steer), .clock_halt(clock_halt), .irq_pending(irq_pending),
        .wake_input_pin(wake_input_pin), .power_switch_out(power_switch_out),
        .power_switch_oe(power_switch_oe), .reset_out_n(reset_out_n), .reset_out_oe(reset_out_oe),
        .clkint_out_enable(clkint_out_enable), .wake_input_enable(wake_input_enable),
        .serial_pins_enable(serial_pins_enable), .internal_out_connect(internal_out_connect),
        .internal_in_disable(internal_in_disable), .sleep_state(sleep_state));
    spsc_host_model i_host (.power_switch_out(power_switch_out), .power_switch_oe(power_switch_oe),
        .reset_out_n(reset_out_n), .reset_out_oe(reset_out_oe), .host_powered(host_powered),
        .host_in_reset(host_in_reset));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask
    // Bits: alarm, countdown int, countdown run, ext, watchdog count, steer, halt, irq
    task automatic drive_src(input logic [7:0] v);
        @(posedge clk);
        {alarm_int_enable, countdown_int_enable, countdown_run, ext_int_enable} <= v[7:4];
        watchdog_count <= {v[3], 4'h0};
        {watchdog_steer, clock_halt, irq_pending} <= v[2:0];
    endtask
    task automatic wake();
        @(posedge clk);
        irq_pending <= 1'b1;
        repeat (3) @(posedge clk);
        irq_pending <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(sleep_state, SPSC_RUN, "state after wake");
    endtask
    task automatic t_reset_values();
        logic [7:0] d;
        rd(8'h1C, d);
        chk(d, 8'h00, "osc ctrl reset");
        rd(8'h30, d);
        chk(d, 8'h00, "out ctrl reset");
        rd(8'h40, d);
        chk(d, 8'h00, "sleep ctrl reset");
        rd(8'h41, d);
        chk(d, 8'hC7, "switch ctrl reset");
        rd(8'h55, d);
        chk(d, 8'h00, "unmapped read");
        chk(pins, 10'h3FD, "pins after reset");
        $display("test reset values done");
    endtask
    task automatic t_lock();
        logic [7:0] d;
        wr(8'h41, 8'hE7);
        rd(8'h41, d);
        chk(d, 8'hC7, "static level while locked");
        wr(8'h41, 8'h87);
        wr(8'h41, 8'hA7);
        rd(8'h41, d);
        chk(d, 8'hA7, "static level unlocked");
        chk({power_switch_oe, host_powered}, 2'b00, "switch open on static one");
        wr(8'h41, 8'h87);
        repeat (2) @(posedge clk);
        #1 chk({power_switch_oe, host_powered}, 2'b11, "switch closed on static zero");
        wr(8'h41, 8'h27);
        repeat (2) @(posedge clk);
        #1 chk({power_switch_out, power_switch_oe}, 2'b11, "push-pull switch on static one");
        wr(8'h41, 8'h87);
        $display("test switch lock done");
    endtask
    task automatic t_accept();
        logic [8:0] tbl [10] = '{9'h000, 9'h181, 9'h021, 9'h080, 9'h040, 9'h0C1, 9'h011, 9'h018, 9'h104, 9'h102};
        logic [7:0] d;
        foreach (tbl[i])
        begin
            drive_src(tbl[i][8:1]);
            wr(8'h40, 8'h80);
            rd(8'h40, d);
            chk(d, tbl[i][0] ? 8'hA0 : 8'h00, "request readback");
            chk(sleep_state, tbl[i][0] ? SPSC_SLEEP : SPSC_RUN, "state after request");
            if (tbl[i][0])
            begin
                wake();
                rd(8'h40, d);
                chk(d, 8'h20, "flag kept after wake");
                wr(8'h40, 8'h00);
            end
        end
        $display("test request acceptance done");
    endtask
    task automatic t_pins();
        logic [7:0] d;
        logic [33:0] cfg [2] = '{{8'h04, 8'h10, 8'h80, 10'h062}, {8'h00, 8'h2F, 8'hC0, 10'h19C}};
        wr(8'h41, 8'h86);
        drive_src(8'h80);
        foreach (cfg[i])
        begin
            wr(8'h1C, cfg[i][33:26]);
            wr(8'h30, cfg[i][25:18]);
            wr(8'h40, cfg[i][17:10]);
            repeat (3) @(posedge clk);
            #1 chk(pins, cfg[i][9:0], "pins in sleep");
            chk(host_in_reset, i == 1, "host reset in sleep");
            wake();
            #1 chk(pins, 10'h3FD, "pins after wake");
            wr(8'h40, 8'h00);
        end
        wr(8'h1C, 8'h00);
        wr(8'h30, 8'h00);
        $display("test sleep pins done");
    endtask
    task automatic t_wait();
        logic [7:0] d;
        int n;
        drive_src(8'h80);
        wr(8'h40, 8'h82);
        #1 chk(sleep_state, SPSC_SWAIT, "state during wait");
        n = 0;
        while (sleep_state !== SPSC_SLEEP && n < 200)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk(n >= 40 && n <= 62, 1'b1, "wait length");
        wake();
        wr(8'h40, 8'h00);
        wr(8'h40, 8'h83);
        repeat (5) @(posedge clk);
        wake();
        rd(8'h40, d);
        chk(d, 8'h03, "aborted wait readback");
        $display("test sleep wait done");
    endtask
    task automatic t_status();
        logic [7:0] d;
        drive_src(8'h80);
        wake_input_pin <= 1'b1;
        rd(8'h42, d);
        chk(d & 8'h03, 8'h03, "status pin high, armed");
        drive_src(8'h00);
        wake_input_pin <= 1'b0;
        rd(8'h42, d);
        chk(d & 8'h03, 8'h00, "status pin low, unarmed");
        $display("test status done");
    endtask
    initial
    begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 18'h0};
        {alarm_int_enable, countdown_int_enable, countdown_run, ext_int_enable} = 4'h0;
        {watchdog_count, watchdog_steer, clock_halt, irq_pending, wake_input_pin} = 9'h000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_lock();
        t_accept();
        t_pins();
        t_wait();
        t_status();
        final_report();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report();
    end
endmodule // sleep_power_switch_control_tb_top
